// >>> rtl/stc_pkg.sv
// shared constants and carrier types for the transceiver control/status block
package stc_pkg;
  // line rates, encoding as the rate select pair {bit1,bit0}
  typedef enum logic [1:0] {
    STC_RATE_OC48 = 2'h0,
    STC_RATE_OC24 = 2'h1,
    STC_RATE_OC12 = 2'h2,
    STC_RATE_OC3 = 2'h3
  } stc_rate_e;
  // operating mode encoding {bit1,bit0}
  typedef enum logic [1:0] {
    STC_MODE_DUPLEX = 2'h0,
    STC_MODE_RX_ONLY = 2'h1,
    STC_MODE_TX_ONLY = 2'h2,
    STC_MODE_REPEATER = 2'h3
  } stc_mode_e;
  // clock and timing
  localparam int unsigned STC_CLK_MHZ = 125;
  localparam real STC_LOS_TIME_US = 2.3;
  // longest quiet time before loss of signal, rounded down to whole cycles
  localparam int unsigned STC_LOS_CYCLES = int'($floor(STC_LOS_TIME_US * STC_CLK_MHZ));
  localparam int unsigned STC_LOS_CNT_W = 9;
  // pattern checker
  localparam int unsigned STC_PRBS_W = 7;
  localparam logic [6:0] STC_PRBS_SEED = 7'h7F;
  localparam logic [3:0] STC_PASS_RUN = 4'hF;
  // fifo pointer width and reset value of write-ahead spacing
  localparam int unsigned STC_FIFO_AW = 3;
  localparam logic [2:0] STC_FIFO_WR_RST = 3'h4;
  // register interface offsets
  localparam logic [3:0] STC_REG_CTRL = 4'h0;
  localparam logic [3:0] STC_REG_STATUS = 4'h4;
  localparam logic [3:0] STC_REG_IRQ = 4'h8;
  localparam logic [3:0] STC_REG_MASK = 4'hC;
  // interrupt status bit positions
  localparam int unsigned STC_IRQ_LOS = 0;
  localparam int unsigned STC_IRQ_COLL = 1;
  localparam int unsigned STC_IRQ_PASS = 2;
  localparam int unsigned STC_IRQ_W = 3;
  localparam logic [2:0] STC_MASK_RST = 3'h0;
  // strap pins grouped as they arrive from board or framer
  typedef struct packed {
    logic pattern_test_enable;
    logic detect_polarity_select;
    logic optical_signal_detect;
    logic rate_autodetect_enable;
    logic remote_loopback_enable;
    logic rate_select_bit1;
    logic rate_select_bit0;
    logic repeater_listen_enable;
    logic factory_test_mode;
    logic deemphasis_bit2;
    logic deemphasis_bit1;
    logic operating_mode_bit1;
    logic operating_mode_bit0;
    logic fifo_reset_n;
  } stc_pins_s;
  // per-block power enables derived from mode
  typedef struct packed {
    logic tx_on;
    logic rx_on;
    logic demux_on;
  } stc_power_s;
endpackage

// >>> rtl/stc_ctrl.sv
// control and status logic of a multirate serial transceiver
module stc_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // pins from board straps or framer
  input wire stc_pkg::stc_pins_s pins,
  // serial-side data, one bit per cycle at this rate
  input wire logic serial_in,
  input wire logic tx_par_bit,
  input wire logic tx_wr_en,
  output logic serial_out,
  output logic rx_par_bit,
  output logic rx_par_valid,
  // status to framer
  output logic pattern_check_pass,
  output logic signal_absent_flag,
  output logic cdr_lock_flag,
  output logic detected_rate_code_bit0,
  output logic detected_rate_code_bit1,
  output logic tx_fifo_collision,
  output logic [1:0] deemphasis_level,
  output stc_pkg::stc_power_s power_en,
  output logic [1:0] line_rate,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  logic rst_s1_ff, rst_s2_ff;
  stc_pkg::stc_pins_s pins_s1_ff, pins_ff;
  logic ser_s1_ff, ser_ff, ser_d_ff;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rst_n = rst_s2_ff;
  // every pin is asynchronous to core_clk, so two stages first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_s1_ff <= '0;
      pins_ff <= '0;
      ser_s1_ff <= 1'b0;
      ser_ff <= 1'b0;
      ser_d_ff <= 1'b0;
    end else begin
      pins_s1_ff <= pins;
      pins_ff <= pins_s1_ff;
      ser_s1_ff <= serial_in;
      ser_ff <= ser_s1_ff;
      ser_d_ff <= ser_ff;
    end
  end

  function automatic logic [6:0] prbs_step(input logic [6:0] s);
    prbs_step = {s[5:0], s[6] ^ s[5]};
  endfunction

  // mode and power decode
  wire stc_pkg::stc_mode_e mode = stc_pkg::stc_mode_e'({pins_ff.operating_mode_bit1,
                                                         pins_ff.operating_mode_bit0});
  wire is_rep = (mode == stc_pkg::STC_MODE_REPEATER);
  wire tx_on = (mode != stc_pkg::STC_MODE_RX_ONLY);
  wire rx_on = (mode != stc_pkg::STC_MODE_TX_ONLY);
  wire demux_on = is_rep ? pins_ff.repeater_listen_enable : rx_on;
  wire [1:0] sel_rate = {pins_ff.rate_select_bit1, pins_ff.rate_select_bit0};
  wire sig_active = pins_ff.optical_signal_detect ^ pins_ff.detect_polarity_select;
  wire fifo_rst = !pins_ff.fifo_reset_n;

  // loss of signal: quiet-line counter
  logic [stc_pkg::STC_LOS_CNT_W-1:0] quiet_ff;
  logic los_ff;
  wire edge_seen = ser_ff ^ ser_d_ff;
  wire quiet_max = (quiet_ff == stc_pkg::STC_LOS_CNT_W'(stc_pkg::STC_LOS_CYCLES));
  wire [stc_pkg::STC_LOS_CNT_W-1:0] nxt_quiet = edge_seen ? '0 :
    (quiet_max ? quiet_ff : quiet_ff + 1'b1);
  wire nxt_los = sig_active || quiet_max;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_ff <= '0;
      los_ff <= 1'b0;
    end else begin
      quiet_ff <= nxt_quiet;
      los_ff <= nxt_los;
    end
  end

  // lock flag: stands for recovery lock, cleared by reset pin or line loss
  logic lock_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) lock_ff <= 1'b0;
    else lock_ff <= !fifo_rst && rx_on && !los_ff && edge_seen ? 1'b1 :
                    (fifo_rst || los_ff ? 1'b0 : lock_ff);
  end

  // transmit fifo: a small circular buffer; read side runs every cycle,
  // so a stalled writer lets pointers meet, which the collision flag reports
  logic [(1<<stc_pkg::STC_FIFO_AW)-1:0] fifo_ff;
  logic [stc_pkg::STC_FIFO_AW-1:0] wp_ff, rp_ff;
  logic coll_ff;
  wire [stc_pkg::STC_FIFO_AW-1:0] nxt_wp = wp_ff + (tx_wr_en ? 1'b1 : 1'b0);
  wire [stc_pkg::STC_FIFO_AW-1:0] nxt_rp = rp_ff + 1'b1;
  wire clash = (nxt_wp == nxt_rp);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_ff <= '0;
      wp_ff <= stc_pkg::STC_FIFO_WR_RST;
      rp_ff <= '0;
      coll_ff <= 1'b0;
    end else if (fifo_rst || !tx_on) begin
      wp_ff <= stc_pkg::STC_FIFO_WR_RST;
      rp_ff <= '0;
      coll_ff <= 1'b0;
    end else begin
      if (tx_wr_en) fifo_ff[wp_ff] <= tx_par_bit;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      coll_ff <= coll_ff || clash;
    end
  end

  // pattern generator and checker
  logic [6:0] gen_ff, chk_ff;
  logic [3:0] run_ff;
  logic pass_ff;
  wire pat_en = pins_ff.pattern_test_enable;
  wire [6:0] chk_pred = prbs_step(chk_ff);
  wire pat_ok = (ser_ff == chk_pred[0]);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_ff <= stc_pkg::STC_PRBS_SEED;
      chk_ff <= stc_pkg::STC_PRBS_SEED;
      run_ff <= '0;
      pass_ff <= 1'b0;
    end else if (!pat_en) begin
      run_ff <= '0;
      pass_ff <= 1'b0;
    end else begin
      gen_ff <= prbs_step(gen_ff);
      chk_ff <= {chk_ff[5:0], ser_ff}; // self-synchronising checker
      run_ff <= !pat_ok ? '0 : (run_ff == stc_pkg::STC_PASS_RUN ? run_ff : run_ff + 1'b1);
      pass_ff <= pat_ok && (run_ff == stc_pkg::STC_PASS_RUN);
    end
  end

  // serial output selection: absent forces zeroes over loopback and pattern
  logic sout_ff, rxp_ff, rxv_ff;
  wire fifo_q = fifo_ff[rp_ff];
  wire nxt_sout = !tx_on || los_ff ? 1'b0 :
    (pins_ff.remote_loopback_enable || is_rep) ? ser_ff :
    (pat_en ? gen_ff[0] : fifo_q);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sout_ff <= 1'b0;
      rxp_ff <= 1'b0;
      rxv_ff <= 1'b0;
    end else begin
      sout_ff <= nxt_sout;
      rxp_ff <= demux_on ? ser_ff : 1'b0;
      rxv_ff <= demux_on;
    end
  end

  // rate reporting and de-emphasis level
  logic [1:0] rate_ff, code_ff, deemph_ff;
  logic [2:0] pwr_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_ff <= stc_pkg::STC_RATE_OC48;
      code_ff <= '0;
      deemph_ff <= '0;
      pwr_ff <= '0;
    end else begin
      rate_ff <= pins_ff.rate_autodetect_enable ? code_ff : sel_rate;
      // detected code tracks the rate select pins; only reported when enabled
      code_ff <= pins_ff.rate_autodetect_enable ? sel_rate : '0;
      deemph_ff <= {pins_ff.deemphasis_bit2, pins_ff.deemphasis_bit1};
      pwr_ff <= {tx_on, rx_on, demux_on};
    end
  end

  // interrupt status, mask and status register readback
  logic [stc_pkg::STC_IRQ_W-1:0] ist_ff, msk_ff;
  logic [31:0] rd_ff;
  logic irq_ff, los_d_ff, pass_d_ff;
  wire [stc_pkg::STC_IRQ_W-1:0] ev = {pass_ff & ~pass_d_ff, coll_ff, los_ff & ~los_d_ff};
  wire wr_ist = reg_wr && (reg_addr == stc_pkg::STC_REG_IRQ);
  wire [stc_pkg::STC_IRQ_W-1:0] clr = wr_ist ? reg_wdata[stc_pkg::STC_IRQ_W-1:0] : '0;
  wire [stc_pkg::STC_IRQ_W-1:0] nxt_ist = (ist_ff & ~clr) | ev;
  wire [31:0] stat_word = {22'h0, rate_ff, code_ff, deemph_ff, lock_ff, coll_ff, los_ff,
                           pass_ff};
  wire [31:0] nxt_rd = (reg_addr == stc_pkg::STC_REG_STATUS) ? stat_word :
    (reg_addr == stc_pkg::STC_REG_IRQ) ? {29'h0, ist_ff} :
    (reg_addr == stc_pkg::STC_REG_MASK) ? {29'h0, msk_ff} : 32'h0;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ist_ff <= '0;
      msk_ff <= stc_pkg::STC_MASK_RST;
      rd_ff <= '0;
      irq_ff <= 1'b0;
      los_d_ff <= 1'b0;
      pass_d_ff <= 1'b0;
    end else begin
      ist_ff <= nxt_ist;
      if (reg_wr && reg_addr == stc_pkg::STC_REG_MASK) msk_ff <= reg_wdata[2:0];
      rd_ff <= reg_rd ? nxt_rd : 32'h0;
      irq_ff <= |(nxt_ist & msk_ff);
      los_d_ff <= los_ff;
      pass_d_ff <= pass_ff;
    end
  end

  assign serial_out = sout_ff;
  assign rx_par_bit = rxp_ff;
  assign rx_par_valid = rxv_ff;
  assign pattern_check_pass = pass_ff;
  assign signal_absent_flag = los_ff;
  assign cdr_lock_flag = lock_ff;
  assign detected_rate_code_bit0 = code_ff[0];
  assign detected_rate_code_bit1 = code_ff[1];
  assign tx_fifo_collision = coll_ff;
  assign deemphasis_level = deemph_ff;
  assign power_en = pwr_ff;
  assign line_rate = rate_ff;
  assign reg_rdata = rd_ff;
  assign irq = irq_ff;

  // pattern test
  a_pass_low_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pat_en |=> !pass_ff)
    else $error("pass high with pattern off");
  a_pass_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(pass_ff) |-> $past(pat_en) && $past(pat_ok))
    else $error("pass raised without a matching bit");
  a_pass_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
    pat_en && !pat_ok |=> !pass_ff)
    else $error("pass held over a wrong bit");
  a_gen_live: assert property (@(posedge core_clk) disable iff (!rst_n)
    pat_en && tx_on && !los_ff && !is_rep && !pins_ff.remote_loopback_enable
    |=> sout_ff == $past(gen_ff[0]))
    else $error("generator not on the line");

  // signal detect, loss of signal and loopback
  a_absent_on_detect: assert property (@(posedge core_clk) disable iff (!rst_n)
    sig_active |=> los_ff)
    else $error("absent not raised");
  a_normal_flow: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sig_active && !quiet_max |=> !los_ff)
    else $error("absent raised on a live line");
  a_zero_on_absent: assert property (@(posedge core_clk) disable iff (!rst_n)
    los_ff |=> !sout_ff)
    else $error("data sent during absence");
  a_quiet_los: assert property (@(posedge core_clk) disable iff (!rst_n)
    quiet_max |=> los_ff)
    else $error("quiet line not flagged");
  a_loop_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    pins_ff.remote_loopback_enable && tx_on && !los_ff |=> sout_ff == $past(ser_ff))
    else $error("loopback data wrong");

  // rate, de-emphasis, mode and power
  a_code_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pins_ff.rate_autodetect_enable |=> code_ff == 2'h0)
    else $error("rate code shown without autodetect");
  a_code_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    pins_ff.rate_autodetect_enable |=> code_ff == $past(sel_rate))
    else $error("rate code not reported");
  a_rate_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pins_ff.rate_autodetect_enable |=> rate_ff == $past(sel_rate))
    else $error("line rate not from select pins");
  a_deemph_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    pins_ff.deemphasis_bit2 || !pins_ff.deemphasis_bit2
    |=> deemph_ff[1] == $past(pins_ff.deemphasis_bit2) && deemph_ff[0] == $past(pins_ff.deemphasis_bit1))
    else $error("de-emphasis level wrong");
  a_demux_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    is_rep && !pins_ff.repeater_listen_enable |=> !rxv_ff && !rxp_ff)
    else $error("demux on while not listening");
  a_listen_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    is_rep && pins_ff.repeater_listen_enable |=> rxv_ff && (rxp_ff == $past(ser_ff)))
    else $error("listen data missing");
  a_tx_only_power: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == stc_pkg::STC_MODE_TX_ONLY |=> pwr_ff == 3'h4)
    else $error("transmit only power wrong");
  a_rx_only_power: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == stc_pkg::STC_MODE_RX_ONLY |=> pwr_ff == 3'h3)
    else $error("receive only power wrong");
  a_duplex_power: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == stc_pkg::STC_MODE_DUPLEX |=> pwr_ff == 3'h7)
    else $error("duplex power wrong");
  a_tx_off_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    !tx_on |=> !sout_ff)
    else $error("serial output live with transmitter off");

  // fifo, lock and interrupt status
  a_coll_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    coll_ff && !fifo_rst && tx_on |=> coll_ff)
    else $error("collision lost");
  a_coll_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    clash && !fifo_rst && tx_on |=> coll_ff)
    else $error("collision not flagged");
  a_fifo_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !tx_on |=> !coll_ff)
    else $error("collision with transmitter off");
  a_fifo_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    fifo_rst |=> !coll_ff && !lock_ff)
    else $error("reset ignored");
  a_event_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    ev[stc_pkg::STC_IRQ_LOS] |=> ist_ff[stc_pkg::STC_IRQ_LOS])
    else $error("absent event lost");

  // main scenarios
  c_pass: cover property (@(posedge core_clk) disable iff (!rst_n) pass_ff);
  c_los: cover property (@(posedge core_clk) disable iff (!rst_n) quiet_max);
  c_coll: cover property (@(posedge core_clk) disable iff (!rst_n) coll_ff);
  c_listen: cover property (@(posedge core_clk) disable iff (!rst_n) is_rep && rxv_ff);
  c_auto: cover property (@(posedge core_clk) disable iff (!rst_n) pins_ff.rate_autodetect_enable);
endmodule // stc_ctrl

// >>> verif/stc_far_end.sv
// far-end framer model: drives the serial line into the control block
module stc_far_end (
  // clock
  input wire logic core_clk,
  // line behaviour: 0 quiet, 1 toggling, 2 loop back, 3 loop back inverted
  input wire logic [1:0] line_mode,
  // serial line
  input wire logic dev_serial_out,
  output logic dev_serial_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // starts defined so the toggling mode never inverts an unknown
  initial dev_serial_in = 1'b0;
  always @(posedge core_clk) begin
    case (line_mode)
      2'h0: dev_serial_in <= dev_serial_in;
      2'h1: dev_serial_in <= ~dev_serial_in;
      2'h2: dev_serial_in <= dev_serial_out;
      default: dev_serial_in <= ~dev_serial_out;
    endcase
  end
endmodule // stc_far_end

// >>> verif/testbench.sv
// self-checking bench for the transceiver control/status block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, tx_par_bit, tx_wr_en, reg_wr, reg_rd;
  logic serial_in, serial_out, rx_par_bit, rx_par_valid, irq, pass, absent, lock, coll;
  logic rc0, rc1;
  logic [1:0] deemph, line_rate, line_mode;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  stc_pkg::stc_pins_s pins;
  stc_pkg::stc_power_s power_en;
  int n_mismatch, total_checks;
  wire logic [4:0] mon = {pass, absent, coll, irq, serial_out};
  // row: rsel, mode, deemph in, listen, then expected rate, deemph, power
  logic [13:0] rows [5] = '{14'b00_00_00_0_00_00_111, 14'b01_01_01_0_01_01_011,
    14'b10_10_10_0_10_10_100, 14'b11_11_11_1_11_11_111, 14'b00_11_00_0_00_00_110};
  stc_ctrl u_stc_ctrl (.core_clk(core_clk), .rstn(rstn), .pins(pins), .serial_in(serial_in),
    .tx_par_bit(tx_par_bit), .tx_wr_en(tx_wr_en), .serial_out(serial_out),
    .rx_par_bit(rx_par_bit), .rx_par_valid(rx_par_valid), .pattern_check_pass(pass),
    .signal_absent_flag(absent), .cdr_lock_flag(lock), .detected_rate_code_bit0(rc0),
    .detected_rate_code_bit1(rc1), .tx_fifo_collision(coll), .deemphasis_level(deemph),
    .power_en(power_en), .line_rate(line_rate), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  stc_far_end u_stc_far_end (.core_clk(core_clk), .line_mode(line_mode),
    .dev_serial_out(serial_out), .dev_serial_in(serial_in));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // bounded wait on one monitored output; running out ends the run
  task wt(input int b, input logic v, input int lim);
    for (int i = 0; i < lim && mon[b] !== v; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk(mon[b], v);
    if (mon[b] !== v) final_report();
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, line_mode} = '0;
    pins = '0;
    pins.fifo_reset_n = 1'b1;
    {tx_par_bit, tx_wr_en, line_mode} = 4'h7;
    repeat (10) @(posedge core_clk);
    chk({pass, absent, coll, irq}, 4'h0);
    rstn <= 1'b1;
    repeat (6) @(posedge core_clk);
    foreach (rows[k]) begin
      {pins.rate_select_bit1, pins.rate_select_bit0} <= rows[k][13:12];
      {pins.operating_mode_bit1, pins.operating_mode_bit0} <= rows[k][11:10];
      {pins.deemphasis_bit2, pins.deemphasis_bit1} <= rows[k][9:8];
      pins.repeater_listen_enable <= rows[k][7];
      repeat (8) @(posedge core_clk);
      chk(line_rate, rows[k][6:5]);
      chk(deemph, rows[k][4:3]);
      chk(power_en, rows[k][2:0]);
      if (rows[k][11:10] == 2'h3 && !rows[k][7]) chk(rx_par_valid, 1'b0);
      if (rows[k][11:10] == 2'h3 && !rows[k][7]) chk(rx_par_bit, 1'b0);
      chk(rx_par_valid, rows[k][0]);
      @(posedge core_clk);
    end
    // back to duplex with a live line, so later tests see generator and fifo
    {pins.operating_mode_bit1, pins.operating_mode_bit0} <= 2'h0;
    pins.repeater_listen_enable <= 1'b0;
    line_mode <= 2'h1;
    pins.rate_autodetect_enable <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk({rc1, rc0}, stc_pkg::STC_RATE_OC48);
    for (int k = 0; k < 4; k++) begin
      {pins.detect_polarity_select, pins.optical_signal_detect} <= k[1:0];
      repeat (8) @(posedge core_clk);
      chk(absent, k[1] ^ k[0]);
      if (k[1] ^ k[0]) chk(serial_out, 1'b0);
    end
    pins.detect_polarity_select <= 1'b0;
    pins.optical_signal_detect <= 1'b0;
    wr(stc_pkg::STC_REG_IRQ, 32'h7);
    wr(stc_pkg::STC_REG_MASK, 32'h1);
    wt(3, 1'b0, 20);
    line_mode <= 2'h0;
    repeat (250) @(posedge core_clk);
    chk(absent, 1'b0);
    chk(irq, 1'b0);
    wt(3, 1'b1, 60);
    wt(1, 1'b1, 6);
    rd(stc_pkg::STC_REG_STATUS);
    chk(d[1], 1'b1);
    rd(stc_pkg::STC_REG_IRQ);
    chk(d[stc_pkg::STC_IRQ_LOS], 1'b1);
    wr(stc_pkg::STC_REG_IRQ, 32'h1);
    wt(1, 1'b0, 6);
    rd(4'h2);
    chk(d, 32'h0);
    line_mode <= 2'h1;
    wt(3, 1'b0, 20);
    @(posedge core_clk);
    line_mode <= 2'h2;
    pins.pattern_test_enable <= 1'b1;
    wt(4, 1'b1, 300);
    line_mode <= 2'h3;
    wt(4, 1'b0, 100);
    line_mode <= 2'h2;
    wt(4, 1'b1, 300);
    pins.pattern_test_enable <= 1'b0;
    wt(4, 1'b0, 8);
    repeat (20) @(posedge core_clk);
    chk(pass, 1'b0);
    line_mode <= 2'h0;
    pins.remote_loopback_enable <= 1'b1;
    wt(0, serial_in, 10);
    @(posedge core_clk);
    pins.remote_loopback_enable <= 1'b0;
    line_mode <= 2'h1;
    tx_wr_en <= 1'b0;
    wt(2, 1'b1, 20);
    chk(lock, 1'b1);
    pins.fifo_reset_n <= 1'b0;
    wt(2, 1'b0, 8);
    chk(lock, 1'b0);
    pins.fifo_reset_n <= 1'b1;
    tx_wr_en <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk(coll, 1'b0);
    final_report();
  end
endmodule // testbench
